// ### rtl/ctw_pkg.sv
package ctw_pkg;

  // clock period in picoseconds (250 MHz)
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // wake filter window; a 500 kbps bit and two 1 Mbps bits both last 2 us
  localparam int unsigned WAKE_FILTER_NS  = 500;
  localparam int unsigned WAKE_TIMEOUT_US = 1000;

  localparam int unsigned WAKE_FILTER_CYC =
    (WAKE_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_TIMEOUT_CYC =
    (WAKE_TIMEOUT_US * 1000 * 1000) / CLK_PERIOD_PS;

  localparam int unsigned FILT_W = 8;
  localparam int unsigned TOUT_W = 20;

  typedef enum logic [1:0] {
    CTW_MODE_NORMAL   = 2'h0,
    CTW_MODE_STANDBY  = 2'h1,
    CTW_MODE_SHUTDOWN = 2'h2
  } ctw_mode_e;

  typedef enum logic [1:0] {
    CTW_WK_IDLE    = 2'h0,
    CTW_WK_WAITREC = 2'h1,
    CTW_WK_WAITDOM = 2'h2,
    CTW_WK_WOKEN   = 2'h3
  } ctw_wake_e;

  // bus comparator results from the analog front end
  typedef struct packed {
    logic main_dom;
    logic lp_dom;
    logic lp_rec;
  } ctw_bus_s;

  // driver pin controls for the two bus lines
  typedef struct packed {
    logic high_line_o;
    logic high_line_oe;
    logic low_line_o;
    logic low_line_oe;
  } ctw_drv_s;

endpackage

// ### rtl/ctw_filter.sv
// qualifies one bus level: pulses once the level has held past the window
module ctw_filter
(
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // control
  input  wire logic enable_i,
  input  wire logic level_i,
  // result
  output logic      qualified_o
);

  logic [ctw_pkg::FILT_W-1:0] count;
  logic [ctw_pkg::FILT_W-1:0] next_count;
  logic                       done;
  logic                       next_done;

  localparam logic [ctw_pkg::FILT_W-1:0] LIMIT =
    ctw_pkg::FILT_W'(ctw_pkg::WAKE_FILTER_CYC);

  always_comb
  begin
    next_count = count;
    next_done  = done;
    if (!enable_i || !level_i)
    begin
      next_count = '0;
      next_done  = 1'b0;
    end
    else if (count <= LIMIT)
    begin
      next_count = count + 1'b1;
    end
    else
    begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      count <= '0;
      done  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done  <= next_done;
    end
  end

  // level held strictly longer than the window, one pulse per run
  assign qualified_o = next_done && !done;

endmodule

// ### rtl/ctw_top.sv
module ctw_top
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // mode pins
  input  wire logic              standby_select_i,
  input  wire logic              shutdown_select_i,
  // controller side
  input  wire logic              transmit_i,
  output logic                   receive_o,
  // bus comparators
  input  wire ctw_pkg::ctw_bus_s bus_i,
  // bus drivers
  output ctw_pkg::ctw_drv_s      drv_o,
  // status
  output ctw_pkg::ctw_mode_e     mode_o
);

  ctw_pkg::ctw_mode_e         mode;
  ctw_pkg::ctw_mode_e         next_mode;
  ctw_pkg::ctw_wake_e         wstate;
  ctw_pkg::ctw_wake_e         next_wstate;
  logic [ctw_pkg::TOUT_W-1:0] tcount;
  logic [ctw_pkg::TOUT_W-1:0] next_tcount;
  logic                       receive;
  logic                       next_receive;
  ctw_pkg::ctw_drv_s          drv;
  ctw_pkg::ctw_drv_s          next_drv;
  logic                       in_dom;
  logic                       next_in_dom;
  logic                       dom_q;
  logic                       rec_q;
  logic                       mon_en;

  localparam logic [ctw_pkg::TOUT_W-1:0] TOUT_LIMIT =
    ctw_pkg::TOUT_W'(ctw_pkg::WAKE_TIMEOUT_CYC);

  // mode selection
  always_comb
  begin
    if (shutdown_select_i)
      next_mode = ctw_pkg::CTW_MODE_SHUTDOWN;
    else if (standby_select_i)
      next_mode = ctw_pkg::CTW_MODE_STANDBY;
    else
      next_mode = ctw_pkg::CTW_MODE_NORMAL;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      mode <= ctw_pkg::CTW_MODE_SHUTDOWN;
    else
      mode <= next_mode;
  end

  // mode checks
  a_mode_out: assert property (@(posedge clock_i) disable iff (rst_i)
    shutdown_select_i |=> mode_o == ctw_pkg::CTW_MODE_SHUTDOWN)
    else $error("mode output not shutdown");

  // wake monitor only while in standby
  assign mon_en = (mode == ctw_pkg::CTW_MODE_STANDBY);

  ctw_filter u_dom_filter
  (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .enable_i    (mon_en),
    .level_i     (bus_i.lp_dom),
    .qualified_o (dom_q)
  );

  ctw_filter u_rec_filter
  (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .enable_i    (mon_en),
    .level_i     (bus_i.lp_rec),
    .qualified_o (rec_q)
  );

  // wake pattern sequencer with timeout
  always_comb
  begin
    next_wstate = wstate;
    next_tcount = tcount;
    next_in_dom = in_dom;
    if (!mon_en)
    begin
      next_wstate = ctw_pkg::CTW_WK_IDLE;
      next_tcount = '0;
      next_in_dom = 1'b0;
    end
    else
    begin
      case (wstate)
        ctw_pkg::CTW_WK_IDLE:
        begin
          if (dom_q)
          begin
            next_wstate = ctw_pkg::CTW_WK_WAITREC;
            next_tcount = '0;
          end
        end
        ctw_pkg::CTW_WK_WAITREC:
        begin
          next_tcount = tcount + 1'b1;
          if (tcount >= TOUT_LIMIT)
            next_wstate = ctw_pkg::CTW_WK_IDLE;
          else if (rec_q)
            next_wstate = ctw_pkg::CTW_WK_WAITDOM;
        end
        ctw_pkg::CTW_WK_WAITDOM:
        begin
          next_tcount = tcount + 1'b1;
          if (tcount >= TOUT_LIMIT)
            next_wstate = ctw_pkg::CTW_WK_IDLE;
          else if (dom_q)
          begin
            next_wstate = ctw_pkg::CTW_WK_WOKEN;
            next_in_dom = 1'b1;
          end
        end
        ctw_pkg::CTW_WK_WOKEN:
        begin
          if (dom_q)
            next_in_dom = 1'b1;
          else if (!bus_i.lp_dom)
            next_in_dom = 1'b0;
        end
        default:
          next_wstate = ctw_pkg::CTW_WK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wstate <= ctw_pkg::CTW_WK_IDLE;
      tcount <= '0;
      in_dom <= 1'b0;
    end
    else
    begin
      wstate <= next_wstate;
      tcount <= next_tcount;
      in_dom <= next_in_dom;
    end
  end

  // wake monitor checks
  a_tout_exit: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && tcount >= TOUT_LIMIT
      && (wstate == ctw_pkg::CTW_WK_WAITREC
      || wstate == ctw_pkg::CTW_WK_WAITDOM)
      |=> wstate == ctw_pkg::CTW_WK_IDLE)
    else $error("wake timeout did not restart monitor");
  a_tout_start: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_IDLE && dom_q
      |=> wstate == ctw_pkg::CTW_WK_WAITREC && tcount == '0)
    else $error("timeout not started at first dominant");
  a_rec_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_WAITREC && !rec_q
      && tcount < TOUT_LIMIT |=> wstate == ctw_pkg::CTW_WK_WAITREC)
    else $error("monitor lost progress waiting for recessive");
  a_dom_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_WAITDOM && !dom_q
      && tcount < TOUT_LIMIT |=> wstate == ctw_pkg::CTW_WK_WAITDOM)
    else $error("monitor lost progress waiting for dominant");
  a_idle_lp: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_IDLE && !bus_i.lp_dom
      |=> wstate == ctw_pkg::CTW_WK_IDLE)
    else $error("pattern started without low-power dominant");
  a_woken_stay: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_WOKEN
      |=> wstate == ctw_pkg::CTW_WK_WOKEN)
    else $error("woken state left while in standby");
  a_shutdown_select_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    mode == ctw_pkg::CTW_MODE_SHUTDOWN
      |=> wstate == ctw_pkg::CTW_WK_IDLE && !in_dom)
    else $error("wake monitor active in shutdown");

  // receive output and bus drivers
  always_comb
  begin
    next_receive = 1'b1;
    next_drv     = '0;
    case (next_mode)
      ctw_pkg::CTW_MODE_NORMAL:
      begin
        next_receive      = !bus_i.main_dom;
        next_drv.high_line_o  = 1'b1;
        next_drv.low_line_o   = 1'b0;
        next_drv.high_line_oe = !transmit_i;
        next_drv.low_line_oe  = !transmit_i;
      end
      ctw_pkg::CTW_MODE_STANDBY:
        next_receive = !next_in_dom;
      ctw_pkg::CTW_MODE_SHUTDOWN:
        next_receive = 1'b1;
      default:
        next_receive = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      receive <= 1'b1;
      drv     <= '0;
      mode_o  <= ctw_pkg::CTW_MODE_SHUTDOWN;
    end
    else
    begin
      receive <= next_receive;
      drv     <= next_drv;
      mode_o  <= next_mode;
    end
  end

  // output checks
  a_rel_lines: assert property (@(posedge clock_i) disable iff (rst_i)
    !shutdown_select_i && !standby_select_i && transmit_i
      |=> !drv.high_line_oe && !drv.low_line_oe)
    else $error("lines not released for recessive");
  a_rx_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    wstate == ctw_pkg::CTW_WK_WOKEN && standby_select_i
      && !shutdown_select_i && !bus_i.lp_dom
      |=> receive)
    else $error("receive low after dominant ended");
  a_rx_woken: assert property (@(posedge clock_i) disable iff (rst_i)
    mon_en && wstate == ctw_pkg::CTW_WK_WOKEN && standby_select_i
      && !shutdown_select_i && dom_q
      |=> !receive)
    else $error("receive high on filtered dominant after wake");

  assign receive_o = receive;
  assign drv_o     = drv;

  // checks
  a_shutdown_select_prio: assert property (@(posedge clock_i) disable iff (rst_i)
    shutdown_select_i |=> mode == ctw_pkg::CTW_MODE_SHUTDOWN)
    else $error("shutdown select not obeyed");
  a_stby_sel: assert property (@(posedge clock_i) disable iff (rst_i)
    !shutdown_select_i && standby_select_i
      |=> mode == ctw_pkg::CTW_MODE_STANDBY)
    else $error("standby select not obeyed");
  a_tx_dom: assert property (@(posedge clock_i) disable iff (rst_i)
    !shutdown_select_i && !standby_select_i && !transmit_i
      |=> drv.high_line_oe && drv.low_line_oe && drv.high_line_o)
    else $error("dominant not driven");
  a_drv_off: assert property (@(posedge clock_i) disable iff (rst_i)
    (shutdown_select_i || standby_select_i)
      |=> !drv.high_line_oe && !drv.low_line_oe)
    else $error("driver on outside normal mode");
  a_rx_norm: assert property (@(posedge clock_i) disable iff (rst_i)
    !shutdown_select_i && !standby_select_i
      |=> receive == !$past(bus_i.main_dom))
    else $error("receive does not mirror bus");
  a_shutdown_select_rx: assert property (@(posedge clock_i) disable iff (rst_i)
    shutdown_select_i |=> receive ##1 wstate == ctw_pkg::CTW_WK_IDLE)
    else $error("shutdown receive not high");
  a_stby_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    mode == ctw_pkg::CTW_MODE_STANDBY && wstate != ctw_pkg::CTW_WK_WOKEN
      |-> receive_o)
    else $error("receive low before wake");
  a_wake_seq: assert property (@(posedge clock_i) disable iff (rst_i)
    wstate == ctw_pkg::CTW_WK_IDLE ##1 wstate != ctw_pkg::CTW_WK_IDLE
      |-> wstate == ctw_pkg::CTW_WK_WAITREC)
    else $error("wake sequence skipped a step");
  a_tout: assert property (@(posedge clock_i) disable iff (rst_i)
    tcount <= TOUT_LIMIT + 1'b1)
    else $error("wake timeout overrun");
  c_wake: cover property (@(posedge clock_i) disable iff (rst_i)
    wstate == ctw_pkg::CTW_WK_WOKEN && !receive_o);
  c_tout: cover property (@(posedge clock_i) disable iff (rst_i)
    wstate == ctw_pkg::CTW_WK_WAITDOM ##1 wstate == ctw_pkg::CTW_WK_IDLE);
  c_tx: cover property (@(posedge clock_i) disable iff (rst_i)
    drv.high_line_oe ##1 !drv.high_line_oe);
  c_weak: cover property (@(posedge clock_i) disable iff (rst_i)
    mon_en && bus_i.main_dom && !bus_i.lp_dom && !bus_i.lp_rec);
  c_stby: cover property (@(posedge clock_i) disable iff (rst_i)
    mode == ctw_pkg::CTW_MODE_NORMAL ##1 mode == ctw_pkg::CTW_MODE_STANDBY);

endmodule

// ### bench/ctw_bus_model.sv
// bus seen by the comparators: other nodes plus our own driver
module ctw_bus_model
(
  // remote nodes and local driver
  input  wire logic              remote_dom_i,
  // level between the low-power thresholds but above the main one
  input  wire logic              remote_weak_i,
  input  wire ctw_pkg::ctw_drv_s drv_i,
  // comparator view of the bus
  output ctw_pkg::ctw_bus_s      bus_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic dom;
  logic local_dom;

  // local node only counts when both lines are driven to dominant levels
  assign local_dom = drv_i.high_line_oe & drv_i.low_line_oe
                   & drv_i.high_line_o & ~drv_i.low_line_o;
  // wired-and bus: any driver wins, else termination gives recessive
  assign dom = remote_dom_i | local_dom;
  // main, low-power dominant, low-power recessive
  assign bus_o = {dom | remote_weak_i, dom, ~dom & ~remote_weak_i};
endmodule

// ### bench/test_can_transceiver_mode_wake.sv
`define CHK(a, b) \
  check_count++; \
  if ((a) !== (b)) \
  begin \
    mismatches++; \
    $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); \
  end

module test_can_transceiver_mode_wake;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clock_i;
  logic               rst_i;
  logic               standby_select_i;
  logic               shutdown_select_i;
  logic               transmit_i;
  logic               receive_o;
  logic               remote_dom;
  logic               remote_weak;
  ctw_pkg::ctw_bus_s  bus_i;
  ctw_pkg::ctw_drv_s  drv_o;
  ctw_pkg::ctw_mode_e mode_o;
  int                 mismatches;
  int                 check_count;
  int                 cycles;

  // one 500 kbit/s bit, 2 us at 4 ns per cycle
  localparam int BIT_CYC = 500;

  ctw_top dut_u
  (
    .clock_i           (clock_i),
    .rst_i             (rst_i),
    .standby_select_i  (standby_select_i),
    .shutdown_select_i (shutdown_select_i),
    .transmit_i        (transmit_i),
    .receive_o         (receive_o),
    .bus_i             (bus_i),
    .drv_o             (drv_o),
    .mode_o            (mode_o)
  );

  ctw_bus_model bus_u
  (
    .remote_dom_i  (remote_dom),
    .remote_weak_i (remote_weak),
    .drv_i         (drv_o),
    .bus_o         (bus_i)
  );

  always #2 clock_i = ~clock_i;

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // hold the remote bus level for n cycles
  task automatic seg(input logic d, input int n);
    remote_dom = d;
    cyc(n);
  endtask

  task automatic end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      mismatches++;
      end_sim();
    end
  end

  task automatic t_normal();
    standby_select_i  = 1'b0;
    shutdown_select_i = 1'b0;
    transmit_i        = 1'b0;
    cyc(3);
    `CHK(mode_o, ctw_pkg::CTW_MODE_NORMAL)
    `CHK(drv_o, 4'hD)
    `CHK(receive_o, 1'b0)
    transmit_i = 1'b1;
    cyc(3);
    `CHK({drv_o.high_line_oe, drv_o.low_line_oe}, 2'h0)
    `CHK(receive_o, 1'b1)
    seg(1'b1, 3);
    `CHK(receive_o, 1'b0)
    seg(1'b0, 3);
  endtask

  task automatic t_shutdown();
    standby_select_i  = 1'b1;
    shutdown_select_i = 1'b1;
    transmit_i        = 1'b0;
    cyc(3);
    `CHK(mode_o, ctw_pkg::CTW_MODE_SHUTDOWN)
    `CHK({drv_o.high_line_oe, drv_o.low_line_oe}, 2'h0)
    seg(1'b1, 140);
    seg(1'b0, 140);
    seg(1'b1, 140);
    `CHK(receive_o, 1'b1)
    seg(1'b0, 3);
    shutdown_select_i = 1'b0;
    cyc(3);
    `CHK(mode_o, ctw_pkg::CTW_MODE_STANDBY)
    `CHK({drv_o.high_line_oe, drv_o.low_line_oe}, 2'h0)
    `CHK(receive_o, 1'b1)
    transmit_i = 1'b1;
  endtask

  // states below the filter window never form a pattern
  task automatic t_short();
    seg(1'b1, 100);
    seg(1'b0, 100);
    seg(1'b1, 100);
    `CHK(receive_o, 1'b1)
    seg(1'b0, 100);
  endtask

  task automatic t_wake();
    seg(1'b1, 140);
    seg(1'b0, 50);
    seg(1'b1, 50);
    seg(1'b0, 140);
    seg(1'b1, 100);
    `CHK(receive_o, 1'b1)
    cyc(40);
    `CHK(receive_o, 1'b0)
    seg(1'b0, 3);
    `CHK(receive_o, 1'b1)
    seg(1'b1, 100);
    `CHK(receive_o, 1'b1)
    cyc(40);
    `CHK(receive_o, 1'b0)
    seg(1'b0, 3);
    `CHK(receive_o, 1'b1)
    standby_select_i = 1'b0;
    cyc(3);
    `CHK(mode_o, ctw_pkg::CTW_MODE_NORMAL)
  endtask

  // bit-long states wake; a weak level between them is neither state
  task automatic t_bits();
    standby_select_i = 1'b1;
    cyc(3);
    seg(1'b1, BIT_CYC);
    seg(1'b0, BIT_CYC);
    remote_weak = 1'b1;
    cyc(BIT_CYC);
    `CHK(receive_o, 1'b1)
    remote_weak = 1'b0;
    seg(1'b1, BIT_CYC);
    `CHK(receive_o, 1'b0)
    seg(1'b0, 3);
    `CHK(receive_o, 1'b1)
    seg(1'b1, BIT_CYC);
    `CHK(receive_o, 1'b0)
    seg(1'b0, 3);
    standby_select_i = 1'b0;
    cyc(3);
  endtask

  initial
  begin
    clock_i           = 1'b0;
    rst_i             = 1'b1;
    standby_select_i  = 1'b0;
    shutdown_select_i = 1'b0;
    transmit_i        = 1'b1;
    remote_dom        = 1'b0;
    remote_weak       = 1'b0;
    mismatches        = 0;
    check_count       = 0;
    cycles            = 0;
    cyc(12);
    `CHK(mode_o, ctw_pkg::CTW_MODE_SHUTDOWN)
    `CHK(receive_o, 1'b1)
    rst_i = 1'b0;
    t_normal();
    t_shutdown();
    t_short();
    t_wake();
    t_bits();
    end_sim();
  end
endmodule
